// ===== common/uef_pkg.sv
/*
 Shared constants for the endpoint FIFO status, clear and DMA block:
 link register indices, bit positions, masks, reset values, host map.
 Assumes both ends and the bench import it whole.
*/
package uef_pkg;
    // ------------------------------------------------------------
    // link register indices
    // ------------------------------------------------------------
    localparam int AW = 3;
    localparam int DW = 8;
    localparam int CW = 7;
    localparam logic [AW-1:0] IDX_STATUS = 3'h0;
    localparam logic [AW-1:0] IDX_CLEAR = 3'h1;
    localparam logic [AW-1:0] IDX_DMA = 3'h2;
    localparam logic [AW-1:0] IDX_TRIG = 3'h3;
    localparam logic [AW-1:0] IDX_EP2_DATA = 3'h4;
    localparam logic [AW-1:0] IDX_EP0I_DATA = 3'h5;
    localparam logic [AW-1:0] IDX_EP3_DATA = 3'h6;
    localparam logic [AW-1:0] IDX_EP1_DATA = 3'h7;
    // ------------------------------------------------------------
    // field positions and masks
    // ------------------------------------------------------------
    localparam int ST_EP3 = 5;
    localparam int ST_EP2 = 4;
    localparam int ST_EP0I = 0;
    localparam int CLR_EP3 = 6;
    localparam int CLR_EP1 = 5;
    localparam int CLR_EP2 = 4;
    localparam int CLR_EP0O = 1;
    localparam int CLR_EP0I = 0;
    localparam int DMA_EP2 = 1;
    localparam int DMA_EP1 = 0;
    localparam int TRG_EP3 = 6;
    localparam int TRG_EP1_DONE = 5;
    localparam int TRG_EP2 = 4;
    localparam int TRG_EP0O_DONE = 1;
    localparam int TRG_EP0I = 0;
    localparam logic [DW-1:0] CLEAR_MASK = 8'h73;
    localparam logic [DW-1:0] DMA_MASK = 8'h03;
    localparam logic [DW-1:0] TRIG_MASK = 8'h73;
    localparam logic [DW-1:0] STATUS_RST = 8'h00;
    localparam logic [DW-1:0] DMA_RST = 8'h00;
    localparam logic [CW-1:0] EP2_PKT = 7'h40;
    localparam logic [CW-1:0] EP3_DEPTH = 7'h08;
    localparam logic [CW-1:0] EP0I_DEPTH = 7'h08;
    // ------------------------------------------------------------
    // host map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] CT_DEV_TOP = 8'h1c;
    localparam logic [7:0] CT_DMA2_CNT = 8'h20;
    localparam logic [7:0] CT_DMA1_CNT = 8'h24;
    localparam logic [7:0] CT_DMA_STAT = 8'h28;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

// ===== common/uef_link_if.sv
/*
 Link between the host controller and the endpoint FIFO logic.
 Assumes both ends share hclk and hresetn.
*/
`timescale 1ns/1ps
interface uef_link_if (
    input wire logic hclk,
    input wire logic hresetn
);
    import uef_pkg::*;
    logic [AW-1:0] reg_addr;
    logic [DW-1:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic dma_cyc;
    logic [DW-1:0] reg_rdata;
    logic [1:0] dma_req;
    modport dev (
        input hclk, hresetn, reg_addr, reg_wdata, reg_wr, reg_rd, dma_cyc,
        output reg_rdata, dma_req
    );
    modport ctl (
        input hclk, hresetn, reg_rdata, dma_req,
        output reg_addr, reg_wdata, reg_wr, reg_rd, dma_cyc
    );
endinterface

// ===== core/uef_dev.sv
/*
 Endpoint FIFO control: data-present status, FIFO clear, DMA setting,
 packet triggers and byte counts of each endpoint FIFO (no storage).
 Assumes link accesses and USB-side events arrive on hclk.
*/
// Our own choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
module uef_dev (
    uef_link_if.dev lk,
    input wire logic ep0i_sent,
    input wire logic ep2_sent,
    input wire logic ep3_sent,
    input wire logic ep1_rx_load,
    input wire logic ep0o_rx_load,
    input wire logic [uef_pkg::CW-1:0] rx_len,
    output logic ep1_rx_space,
    output logic ep0o_rx_space,
    output logic [uef_pkg::DW-1:0] flush_pulse
);
    import uef_pkg::*;

    // ------------------------------------------------------------
    // link decode
    // ------------------------------------------------------------
    logic [DW-1:0] dma_reg;
    logic [DW-1:0] clr;
    logic [DW-1:0] trg;
    logic [DW-1:0] status;
    logic [DW-1:0] rdata;
    logic [CW-1:0] sb_cnt [2];
    logic sb_full [2];
    logic [CW-1:0] e2_cnt [2];
    logic e2_full [2];
    logic e2_wsel;
    logic e2_rsel;
    logic [CW-1:0] r1_cnt [2];
    logic r1_full [2];
    logic r1_wsel;
    logic r1_rsel;
    logic [CW-1:0] o0_cnt;
    logic o0_full;
    logic e2_space;
    logic e2_wr;
    logic e2_auto;
    logic e2_commit;
    logic r1_rd;
    logic r1_done;
    logic [DW-1:0] flush_reg;

    function automatic logic wr_at(input logic [AW-1:0] idx);
        return lk.reg_wr && lk.reg_addr == idx;
    endfunction

    // write-one strobes live for the carrying write only
    assign clr = wr_at(IDX_CLEAR) ? (lk.reg_wdata & CLEAR_MASK) : 8'h00;
    assign trg = wr_at(IDX_TRIG) ? (lk.reg_wdata & TRIG_MASK) : 8'h00;

    // ------------------------------------------------------------
    // DMA setting
    // ------------------------------------------------------------
    // no interrupt gating hangs off these bits
    always_ff @(posedge lk.hclk or negedge lk.hresetn) begin
        if (!lk.hresetn) begin
            dma_reg <= DMA_RST;
        end else if (wr_at(IDX_DMA)) begin
            dma_reg <= lk.reg_wdata & DMA_MASK;
        end
    end

    // ------------------------------------------------------------
    // endpoint 0 tx (slot 0) and endpoint 3 tx (slot 1)
    // ------------------------------------------------------------
    always_ff @(posedge lk.hclk or negedge lk.hresetn) begin
        if (!lk.hresetn) begin
            for (int j = 0; j < 2; j++) begin
                sb_cnt[j] <= 7'h00;
                sb_full[j] <= 1'b0;
            end
        end else begin
            for (int j = 0; j < 2; j++) begin
                logic fl;
                logic wr;
                logic cm;
                logic sn;
                logic [CW-1:0] dep;
                fl = (j == 0) ? clr[CLR_EP0I] : clr[CLR_EP3];
                wr = (j == 0) ? wr_at(IDX_EP0I_DATA) : wr_at(IDX_EP3_DATA);
                cm = (j == 0) ? trg[TRG_EP0I] : trg[TRG_EP3];
                sn = (j == 0) ? ep0i_sent : ep3_sent;
                dep = (j == 0) ? EP0I_DEPTH : EP3_DEPTH;
                if (fl) begin
                    sb_cnt[j] <= 7'h00;
                    sb_full[j] <= 1'b0;
                end else begin
                    if (sn) begin
                        sb_full[j] <= 1'b0;
                        sb_cnt[j] <= 7'h00;
                    end else if (wr && !sb_full[j] && sb_cnt[j] < dep) begin
                        sb_cnt[j] <= sb_cnt[j] + 7'h01;
                    end
                    // commit after the sent clear: a set wins
                    if (cm && sb_cnt[j] != 7'h00) begin
                        sb_full[j] <= 1'b1;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // endpoint 2 tx, double buffered
    // ------------------------------------------------------------
    assign e2_space = !e2_full[e2_wsel] && e2_cnt[e2_wsel] < EP2_PKT;
    assign e2_wr = wr_at(IDX_EP2_DATA) && e2_space;
    assign e2_auto = e2_wr && dma_reg[DMA_EP2] && lk.dma_cyc
        && e2_cnt[e2_wsel] == EP2_PKT - 7'h01;
    // short packets wait for the software trigger
    assign e2_commit = e2_auto || (trg[TRG_EP2] && !e2_full[e2_wsel]
        && e2_cnt[e2_wsel] != 7'h00);

    always_ff @(posedge lk.hclk or negedge lk.hresetn) begin
        if (!lk.hresetn) begin
            e2_cnt[0] <= 7'h00;
            e2_cnt[1] <= 7'h00;
            e2_full[0] <= 1'b0;
            e2_full[1] <= 1'b0;
            e2_wsel <= 1'b0;
            e2_rsel <= 1'b0;
        end else if (clr[CLR_EP2]) begin
            e2_cnt[0] <= 7'h00;
            e2_cnt[1] <= 7'h00;
            e2_full[0] <= 1'b0;
            e2_full[1] <= 1'b0;
            e2_wsel <= 1'b0;
            e2_rsel <= 1'b0;
        end else begin
            // host drains rsel, writers fill wsel; a full half never
            // takes both, so the two never collide
            if (ep2_sent && e2_full[e2_rsel]) begin
                e2_full[e2_rsel] <= 1'b0;
                e2_cnt[e2_rsel] <= 7'h00;
                e2_rsel <= !e2_rsel;
            end
            if (e2_wr) begin
                e2_cnt[e2_wsel] <= e2_cnt[e2_wsel] + 7'h01;
            end
            if (e2_commit) begin
                e2_full[e2_wsel] <= 1'b1;
                e2_wsel <= !e2_wsel;
            end
        end
    end

    // ------------------------------------------------------------
    // endpoint 1 rx, double buffered
    // ------------------------------------------------------------
    assign r1_rd = lk.reg_rd && lk.reg_addr == IDX_EP1_DATA
        && r1_full[r1_rsel] && r1_cnt[r1_rsel] != 7'h00;
    assign r1_done = (trg[TRG_EP1_DONE] && r1_full[r1_rsel])
        || (r1_rd && lk.dma_cyc && dma_reg[DMA_EP1]
        && r1_cnt[r1_rsel] == 7'h01);

    always_ff @(posedge lk.hclk or negedge lk.hresetn) begin
        if (!lk.hresetn) begin
            r1_cnt[0] <= 7'h00;
            r1_cnt[1] <= 7'h00;
            r1_full[0] <= 1'b0;
            r1_full[1] <= 1'b0;
            r1_wsel <= 1'b0;
            r1_rsel <= 1'b0;
        end else if (clr[CLR_EP1]) begin
            r1_cnt[0] <= 7'h00;
            r1_cnt[1] <= 7'h00;
            r1_full[0] <= 1'b0;
            r1_full[1] <= 1'b0;
            r1_wsel <= 1'b0;
            r1_rsel <= 1'b0;
        end else begin
            if (ep1_rx_load && !r1_full[r1_wsel]) begin
                r1_cnt[r1_wsel] <= rx_len;
                r1_full[r1_wsel] <= 1'b1;
                r1_wsel <= !r1_wsel;
            end
            if (r1_done) begin
                r1_cnt[r1_rsel] <= 7'h00;
                r1_full[r1_rsel] <= 1'b0;
                r1_rsel <= !r1_rsel;
            end else if (r1_rd) begin
                r1_cnt[r1_rsel] <= r1_cnt[r1_rsel] - 7'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // endpoint 0 rx
    // ------------------------------------------------------------
    always_ff @(posedge lk.hclk or negedge lk.hresetn) begin
        if (!lk.hresetn) begin
            o0_cnt <= 7'h00;
            o0_full <= 1'b0;
        end else if (clr[CLR_EP0O] || trg[TRG_EP0O_DONE]) begin
            o0_cnt <= 7'h00;
            o0_full <= 1'b0;
        end else if (ep0o_rx_load && !o0_full) begin
            o0_cnt <= rx_len;
            o0_full <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // flush strobes to the USB engine
    // ------------------------------------------------------------
    // interrupt flags sit outside and see no flush at all
    always_ff @(posedge lk.hclk or negedge lk.hresetn) begin
        if (!lk.hresetn) begin
            flush_reg <= 8'h00;
        end else begin
            flush_reg <= clr;
        end
    end

    // ------------------------------------------------------------
    // status and read mux
    // ------------------------------------------------------------
    always_comb begin
        status = STATUS_RST;
        status[ST_EP3] = sb_full[1];
        status[ST_EP2] = e2_full[0] || e2_full[1];
        status[ST_EP0I] = sb_full[0];
    end

    always_comb begin
        case (lk.reg_addr)
            IDX_STATUS: rdata = status;
            IDX_DMA: rdata = dma_reg;
            // stand-in byte: bytes left in the read half
            IDX_EP1_DATA: rdata = {1'b0, r1_cnt[r1_rsel]};
            default: rdata = 8'h00;
        endcase
    end

    assign lk.reg_rdata = rdata;
    assign lk.dma_req[0] = dma_reg[DMA_EP1] && r1_full[r1_rsel]
        && r1_cnt[r1_rsel] != 7'h00;
    assign lk.dma_req[1] = dma_reg[DMA_EP2] && e2_space;
    assign ep1_rx_space = !r1_full[r1_wsel];
    assign ep0o_rx_space = !o0_full;
    assign flush_pulse = flush_reg;
endmodule

// ===== core/uef_ctl.sv
/*
 Host end: AHB-Lite slave bridging software to the endpoint logic,
 plus a byte DMA engine that answers the endpoint DMA requests.
 Assumes one AHB master, single word transfers, OKAY only.
*/
`timescale 1ns/1ps
module uef_ctl (
    uef_link_if.ctl lk,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata
);
    import uef_pkg::*;

    typedef enum {CT_IDLE, CT_LATCH, CT_LINK} uef_st_e;
    uef_st_e st_reg;
    logic [7:0] a_addr;
    logic a_wr;
    logic [31:0] wd_reg;
    logic [31:0] rd_reg;
    logic [AW-1:0] l_addr;
    logic [DW-1:0] l_wdata;
    logic l_wr;
    logic l_rd;
    logic l_dma;
    logic [7:0] d2_cnt;
    logic [7:0] d1_cnt;
    logic [1:0] done_reg;
    logic [7:0] last_reg;
    logic own_wr;
    logic dma_ok;

    // unused bits of the clear, DMA and trigger registers go out as zero
    function automatic logic [DW-1:0] legal(input logic [AW-1:0] idx,
                                            input logic [DW-1:0] v);
        case (idx)
            IDX_CLEAR: legal = v & CLEAR_MASK;
            IDX_DMA: legal = v & DMA_MASK;
            IDX_TRIG: legal = v & TRIG_MASK;
            default: legal = v;
        endcase
    endfunction

    // ------------------------------------------------------------
    // bus state
    // ------------------------------------------------------------
    always_ff @(posedge lk.hclk or negedge lk.hresetn) begin
        if (!lk.hresetn) begin
            st_reg <= CT_IDLE;
            a_addr <= 8'h00;
            a_wr <= 1'b0;
            wd_reg <= 32'h0;
        end else begin
            case (st_reg)
                CT_IDLE: begin
                    if (hsel && hready && htrans == HTRANS_NONSEQ) begin
                        a_addr <= haddr[7:0];
                        a_wr <= hwrite;
                        st_reg <= CT_LATCH;
                    end
                end
                CT_LATCH: begin
                    wd_reg <= hwdata;
                    st_reg <= CT_LINK;
                end
                CT_LINK: st_reg <= CT_IDLE;
                default: st_reg <= CT_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // link driver: bus access wins, DMA uses idle link cycles
    // ------------------------------------------------------------
    // one quiet cycle between DMA bytes lets dma_req settle
    assign dma_ok = st_reg != CT_LATCH && !l_wr && !l_rd;

    always_ff @(posedge lk.hclk or negedge lk.hresetn) begin
        if (!lk.hresetn) begin
            l_addr <= 3'h0;
            l_wdata <= 8'h00;
            l_wr <= 1'b0;
            l_rd <= 1'b0;
            l_dma <= 1'b0;
        end else begin
            l_wr <= 1'b0;
            l_rd <= 1'b0;
            l_dma <= 1'b0;
            if (st_reg == CT_LATCH && a_addr <= CT_DEV_TOP) begin
                l_addr <= a_addr[4:2];
                l_wdata <= legal(a_addr[4:2], hwdata[7:0]);
                l_wr <= a_wr;
                l_rd <= !a_wr;
            end else if (dma_ok && d2_cnt != 8'h00 && lk.dma_req[1]) begin
                l_addr <= IDX_EP2_DATA;
                l_wdata <= d2_cnt;
                l_wr <= 1'b1;
                l_dma <= 1'b1;
            end else if (dma_ok && d1_cnt != 8'h00 && lk.dma_req[0]) begin
                l_addr <= IDX_EP1_DATA;
                l_rd <= 1'b1;
                l_dma <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // own registers: DMA counts and end status
    // ------------------------------------------------------------
    assign own_wr = st_reg == CT_LINK && a_wr;

    always_ff @(posedge lk.hclk or negedge lk.hresetn) begin
        if (!lk.hresetn) begin
            d2_cnt <= 8'h00;
            d1_cnt <= 8'h00;
            done_reg <= 2'h0;
            last_reg <= 8'h00;
        end else begin
            if (own_wr && a_addr == CT_DMA2_CNT) begin
                d2_cnt <= wd_reg[7:0];
            end else if (l_wr && l_dma) begin
                d2_cnt <= d2_cnt - 8'h01;
            end
            if (own_wr && a_addr == CT_DMA1_CNT) begin
                d1_cnt <= wd_reg[7:0];
            end else if (l_rd && l_dma) begin
                d1_cnt <= d1_cnt - 8'h01;
                last_reg <= lk.reg_rdata;
            end
            // end events set after the clear, so a set wins
            if (own_wr && a_addr == CT_DMA_STAT) begin
                done_reg <= done_reg & ~wd_reg[1:0];
            end
            if (l_wr && l_dma && d2_cnt == 8'h01) begin
                done_reg[0] <= 1'b1;
            end
            if (l_rd && l_dma && d1_cnt == 8'h01) begin
                done_reg[1] <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    always_ff @(posedge lk.hclk or negedge lk.hresetn) begin
        if (!lk.hresetn) begin
            rd_reg <= 32'h0;
        end else if (st_reg == CT_LINK && !a_wr) begin
            if (a_addr <= CT_DEV_TOP) begin
                rd_reg <= {24'h0, lk.reg_rdata};
            end else if (a_addr == CT_DMA2_CNT) begin
                rd_reg <= {24'h0, d2_cnt};
            end else if (a_addr == CT_DMA1_CNT) begin
                rd_reg <= {24'h0, d1_cnt};
            end else if (a_addr == CT_DMA_STAT) begin
                rd_reg <= {16'h0, last_reg, 6'h00, done_reg};
            end else begin
                rd_reg <= 32'h0;
            end
        end
    end

    assign lk.reg_addr = l_addr;
    assign lk.reg_wdata = l_wdata;
    assign lk.reg_wr = l_wr;
    assign lk.reg_rd = l_rd;
    assign lk.dma_cyc = l_dma;
    assign hreadyout = st_reg == CT_IDLE;
    assign hresp = 1'b0;
    assign hrdata = rd_reg;
endmodule

// ===== verification/uef_link_assertions.sv
/*
 Link checker: concurrent assertions on the signals between host end
 and endpoint logic. Assumes tb_top instantiates it beside the link.
*/
`timescale 1ns/1ps
module uef_link_chk
    import uef_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [AW-1:0] reg_addr,
    input wire logic [DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic dma_cyc,
    input wire logic [DW-1:0] reg_rdata,
    input wire logic [1:0] dma_req
);
    // ------------------------------------------------------------
    // shadow of the dma setting, kept from link writes
    // ------------------------------------------------------------
    logic [1:0] en_reg;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            en_reg <= 2'h0;
        end else if (reg_wr && reg_addr == IDX_DMA) begin
            en_reg <= reg_wdata[1:0];
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_byte;
        dma_cyc && (reg_wr || reg_rd);
    endsequence
    sequence s_gap;
        !reg_wr && !reg_rd;
    endsequence
    sequence s_clr;
        reg_wr && reg_addr == IDX_CLEAR;
    endsequence
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    st_reserved_a: assert property (reg_addr == IDX_STATUS |->
        (reg_rdata & 8'hce) == 8'h00) else $error("status spare set");
    dma_read_a: assert property (reg_addr == IDX_DMA |->
        reg_rdata == {6'h00, en_reg}) else $error("dma setting read");
    ep2_req_off_a: assert property (!en_reg[1] |-> !dma_req[1])
        else $error("ep2 request while off");
    ep1_req_off_a: assert property (!en_reg[0] |-> !dma_req[0])
        else $error("ep1 request while off");
    ep2_flush_a: assert property (s_clr ##0 reg_wdata[CLR_EP2] &&
        en_reg[1] |=> dma_req[1]) else $error("ep2 not empty");
    byte_gap_a: assert property (s_byte |=> s_gap)
        else $error("dma bytes back to back");
    clr_spare_a: assert property (s_clr |->
        (reg_wdata & ~CLEAR_MASK) == 8'h00) else $error("clear spare");
    clr_once_a: assert property (s_clr |=> !(reg_wr &&
        reg_addr == IDX_CLEAR)) else $error("clear repeated");
endmodule

// ===== verification/tb_top.sv
/*
 Top bench: AHB master, USB-side events of the endpoint logic, result
 monitor and link checker. Assumes one hclk domain for everything.
*/
`timescale 1ns/1ps
module tb_top;
    import uef_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, ep1_sp, ep0o_sp, rd_ph = 1'b0;
    logic [31:0] hrdata, lfsr = 32'h4b371efa;
    // ep0i, ep2, ep3 sent; ep1, ep0o load
    logic [4:0] ev = 5'h0;
    logic [CW-1:0] rx_len = 7'h01;
    logic [DW-1:0] flush;
    logic [63:0] exp_q[$];
    logic [7:0] fl_q[$];
    logic [7:0] cl[6] = '{8'h40, 8'h20, 8'h10, 8'h02, 8'h01, 8'h00};
    int n_fail = 0;
    int samples_checked = 0;
    int n_dma = 0;
    always #4 hclk = ~hclk;
    uef_link_if lk (.hclk(hclk), .hresetn(hresetn));
    uef_dev uef_dev_i (.lk(lk), .ep0i_sent(ev[0]), .ep2_sent(ev[1]),
        .ep3_sent(ev[2]), .ep1_rx_load(ev[3]), .ep0o_rx_load(ev[4]),
        .rx_len(rx_len), .ep1_rx_space(ep1_sp), .ep0o_rx_space(ep0o_sp),
        .flush_pulse(flush));
    uef_ctl uef_ctl_i (.lk(lk), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata));
    uef_link_chk uef_link_chk_i (.hclk(hclk), .hresetn(hresetn),
        .reg_addr(lk.reg_addr), .reg_wdata(lk.reg_wdata),
        .reg_wr(lk.reg_wr), .reg_rd(lk.reg_rd), .dma_cyc(lk.dma_cyc),
        .reg_rdata(lk.reg_rdata), .dma_req(lk.dma_req));
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task chk(input logic [31:0] got, input logic [31:0] e,
             input logic [31:0] m);
        samples_checked++;
        if ((got & m) !== (e & m)) begin
            n_fail++;
            $display("FAIL %0t got %h expected %h", $time, got, e);
        end
    endtask
    // holds each phase until hready is seen high at an edge
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        @(posedge hclk);
        while (!hreadyout) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (!hreadyout) @(posedge hclk);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back({m, e});
        ahb(1'b0, a, 32'h0);
    endtask
    task clr(input logic [7:0] v);
        if (v != 8'h00) fl_q.push_back(v);
        ahb(1'b1, 8'h04, {24'h0, v});
    endtask
    task pulse(input int k);
        ev[k] <= 1'b1;
        @(posedge hclk);
        ev <= 5'h0;
        repeat (2) @(posedge hclk);
    endtask
    // bounded wait for n more dma bytes on the link
    task wait_dma(input int n);
        int t;
        t = n_dma + n;
        for (int i = 0; i < 2000 && n_dma < t; i++) @(posedge hclk);
        repeat (4) @(posedge hclk);
    endtask
    task tally_and_finish;
        chk(32'(fl_q.size()), 32'h0, 32'hff);
        $display("checked %0d failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // monitor and watchdog
    // ------------------------------------------------------------
    always @(posedge hclk) begin
        if (lk.dma_cyc && (lk.reg_wr || lk.reg_rd)) n_dma++;
        if (rd_ph && hreadyout) begin
            chk(hrdata, exp_q[0][31:0], exp_q[0][63:32]);
            void'(exp_q.pop_front());
        end
        if (hreadyout) rd_ph <= hsel && htrans == HTRANS_NONSEQ && !hwrite;
        if (flush !== 8'h00) begin
            chk({24'h0, flush}, fl_q.size() ? fl_q.pop_front() : 0, 32'hff);
        end
    end
    initial begin
        repeat (20000) @(posedge hclk);
        n_fail++;
        $display("FAIL %0t watchdog expired", $time);
        tally_and_finish();
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(8'h00, 32'h0, 32'hff);
        rd(8'h08, 32'h0, 32'hff);
        ahb(1'b1, 8'h14, lfsr);
        ahb(1'b1, 8'h18, lfsr);
        ahb(1'b1, 8'h0c, 32'h41);
        rd(8'h00, 32'h21, 32'hff);
        pulse(0);
        rd(8'h00, 32'h20, 32'hff);
        clr(8'h40);
        rd(8'h00, 32'h0, 32'hff);
        foreach (cl[i]) clr(cl[i]);
        for (int i = 0; i < 8; i++) begin
            lfsr = nxt(lfsr);
            clr(lfsr[7:0] & CLEAR_MASK);
        end
        rx_len <= {1'b0, lfsr[5:0] | 6'h01};
        pulse(4);
        chk({31'h0, ep0o_sp}, 32'h0, 32'h1);
        clr(8'h02);
        chk({31'h0, ep0o_sp}, 32'h1, 32'h1);
        ahb(1'b1, 8'h08, 32'h2);
        rd(8'h08, 32'h2, 32'hff);
        ahb(1'b1, 8'h20, 32'd64);
        wait_dma(64);
        rd(8'h00, 32'h10, 32'hff);
        chk({31'h0, lk.dma_req[1]}, 32'h1, 32'h1);
        rd(8'h28, 32'h1, 32'h1);
        pulse(1);
        rd(8'h00, 32'h0, 32'hff);
        ahb(1'b1, 8'h28, 32'h1);
        ahb(1'b1, 8'h20, 32'd10);
        wait_dma(10);
        rd(8'h00, 32'h0, 32'hff);
        ahb(1'b1, 8'h0c, 32'h10);
        rd(8'h00, 32'h10, 32'hff);
        clr(8'h10);
        rd(8'h00, 32'h0, 32'hff);
        rd(8'h28, 32'h1, 32'h1);
        ahb(1'b1, 8'h08, 32'h1);
        rx_len <= 7'h05;
        pulse(3);
        ahb(1'b1, 8'h24, 32'd5);
        wait_dma(5);
        rd(8'h28, 32'h2, 32'h2);
        rd(8'h08, 32'h1, 32'hff);
        ahb(1'b1, 8'h08, 32'h0);
        // fill both halves so the flush has something to undo
        pulse(3);
        pulse(3);
        chk({31'h0, ep1_sp}, 32'h0, 32'h1);
        clr(8'h20);
        chk({31'h0, ep1_sp}, 32'h1, 32'h1);
        pulse(3);
        rd(8'h1c, 32'h5, 32'hff);
        ahb(1'b1, 8'h0c, 32'h20);
        rd(8'h1c, 32'h0, 32'hff);
        repeat (4) @(posedge hclk);
        tally_and_finish();
    end
endmodule
